// ---- core/cab_alu.sv ----
// Combinational 8-bit arithmetic and logic unit with flag outputs
`timescale 1ns/100ps
module cab_alu
   import cab_pkg::*;
(
   input  wire cab_op_t    op,
   input  wire logic [7:0] a,
   input  wire logic [7:0] b,
   input  wire logic [7:0] flags_in,
   output logic [7:0]      res,
   output logic [7:0]      flags_out
);
   logic [8:0] sum;
   logic [4:0] half;
   logic       cin;
   logic       is_sub;
   logic       is_logic;
   logic       keep_z;

   always_comb
   begin
      cin      = 1'b0;
      is_sub   = 1'b0;
      is_logic = 1'b0;
      keep_z   = 1'b0;
      sum      = 9'h000;
      half     = 5'h00;
      res      = a;
      case (op)
         OP_ADD, OP_ADC:
         begin
            cin  = (op == OP_ADC) ? flags_in[FLG_C] : 1'b0;
            sum  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            res  = sum[7:0];
         end
         OP_SUB, OP_SBC, OP_BYTE_SUB_IMM, OP_SUB_CARRY_IMM, OP_COMPARE_IMM:
         begin
            is_sub = 1'b1;
            cin    = (op == OP_SBC || op == OP_SUB_CARRY_IMM) ? flags_in[FLG_C] : 1'b0;
            keep_z = (op == OP_SBC || op == OP_SUB_CARRY_IMM);
            sum    = {1'b0, a} - {1'b0, b} - {8'h00, cin};
            half   = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
            res    = sum[7:0];
         end
         OP_AND_IMM, OP_TEST:
         begin
            is_logic = 1'b1;
            res      = a & b;
         end
         OP_OR_IMM, OP_SET_MASK:
         begin
            is_logic = 1'b1;
            res      = a | b;
         end
         OP_CLEAR_MASK:
         begin
            is_logic = 1'b1;
            res      = a & (8'hFF - b);
         end
         default:
         begin
            res = a;
         end
      endcase
   end

   logic v_add;
   logic v_sub;
   logic z_new;
   assign v_add = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
   assign v_sub = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
   // Carry-chained subtracts only ever clear zero, for multi-byte compares
   assign z_new = keep_z ? ((res == 8'h00) & flags_in[FLG_Z]) : (res == 8'h00);

   always_comb
   begin
      flags_out = flags_in;
      flags_out[FLG_Z] = z_new;
      flags_out[FLG_N] = res[7];
      if (is_logic)
      begin
         flags_out[FLG_V] = 1'b0;
      end
      else
      begin
         flags_out[FLG_V] = is_sub ? v_sub : v_add;
         flags_out[FLG_C] = sum[8];
         flags_out[FLG_H] = half[4];
      end
      flags_out[FLG_S] = flags_out[FLG_N] ^ flags_out[FLG_V];
   end
endmodule

// ---- core/cab_execute.sv ----
// Execute stage for arithmetic, logic, compare, skip, jump, call and branch
// *********************************************
// Contract
// - Register add with/without carry, flags, 1 cycle
// - Word add immediate on pair, 2 cycles
// - Word subtract immediate on pair, 2 cycles
// - Byte subtract immediate, flags, 1 cycle
// - Register subtract with carry, 1 cycle
// - Immediate subtract with carry, 1 cycle
// - AND immediate, Z N V S only
// - OR immediate, Z N V S only
// - Set mask bits via OR, 1 cycle
// - Clear mask bits via AND complement
// - Test register: AND self, flags only
// - Pointer jump loads PC, 2 cycles
// - Pointer call pushes return, 3 cycles
// - Compare skip equal skips next instruction
// - Compare immediate sets flags, no write
// - Skip on general register bit match
// - Skip on I/O register bit match
// - Branch on selected status bit, PC+k+1
// - Signed branch on N xor V
// - Unsigned branch on carry flag
// - Half-carry, T, V branches on flag value
// - Interrupt-state branch on I flag
// *********************************************
`timescale 1ns/100ps
module cab_execute
   import cab_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        instr_valid,
   input  wire cab_instr_t  instr,
   input  wire logic [7:0]  dst_data,
   input  wire logic [7:0]  src_data,
   input  wire logic [7:0]  pair_hi_data,
   input  wire logic [15:0] pointer_data,
   input  wire logic [7:0]  io_data,
   input  wire logic [15:0] stack_data,
   output logic             busy_r,
   output logic             done_r,
   output logic [15:0]      pc_r,
   output logic [7:0]       status_flags_register,
   output cab_wr_t          wr_lo_r,
   output cab_wr_t          wr_hi_r,
   output logic             push_r,
   output logic [15:0]      push_data_r,
   output logic             pop_r
);
   // *********************************************
   // Shared helpers
   // *********************************************
   function automatic logic [15:0] pc_rel(input logic [15:0] pc, input logic [15:0] k);
      pc_rel = pc + k + PC_STEP;
   endfunction

   // *********************************************
   // Decode and condition evaluation
   // *********************************************
   cab_op_t    op;
   logic [7:0] alu_b;
   logic [7:0] alu_res;
   logic [7:0] alu_flags;
   logic       is_alu;
   logic       alu_writes;
   logic       is_word;
   logic       is_skip;
   logic       is_branch;
   logic       cond;
   logic       flag_bit;

   assign op = instr.op;
   assign is_alu = (op == OP_ADD) || (op == OP_ADC) || (op == OP_SUB) || (op == OP_SBC)
                   || (op == OP_BYTE_SUB_IMM) || (op == OP_SUB_CARRY_IMM) || (op == OP_AND_IMM)
                   || (op == OP_OR_IMM) || (op == OP_SET_MASK) || (op == OP_CLEAR_MASK)
                   || (op == OP_TEST) || (op == OP_COMPARE_IMM);
   // Compare and test only touch flags
   assign alu_writes = is_alu && (op != OP_COMPARE_IMM) && (op != OP_TEST);
   assign alu_b = (op == OP_ADD || op == OP_ADC || op == OP_SUB || op == OP_SBC) ? src_data
                : (op == OP_TEST) ? dst_data : instr.imm;
   assign is_word = (op == OP_WORD_ADD_IMM) || (op == OP_WORD_SUB_IMM);
   assign is_skip = (op == OP_COMPARE_SKIP_EQ) || (op == OP_SKIP_REG_BIT) || (op == OP_SKIP_IO_BIT);
   assign is_branch = (op == OP_BRANCH_FLAG) || (op == OP_BRANCH_SIGNED_GE)
                      || (op == OP_BRANCH_UNSIGNED_GE);

   cab_alu u_alu
   (
      .op        (op),
      .a         (dst_data),
      .b         (alu_b),
      .flags_in  (status_flags_register),
      .res       (alu_res),
      .flags_out (alu_flags)
   );

   // Generic flag index covers Z, C, N, H, T, V and I branches
   assign flag_bit = status_flags_register[instr.bitsel];

   always_comb
   begin
      case (op)
         OP_COMPARE_SKIP_EQ:    cond = (dst_data == src_data);
         OP_SKIP_REG_BIT:       cond = (src_data[instr.bitsel] == instr.polarity);
         OP_SKIP_IO_BIT:        cond = (io_data[instr.bitsel] == instr.polarity);
         OP_BRANCH_FLAG:        cond = (flag_bit == instr.polarity);
         // Polarity 0 is the greater-or-equal form: taken while the tested value is 0
         OP_BRANCH_SIGNED_GE:   cond = ((status_flags_register[FLG_N] ^ status_flags_register[FLG_V])
                                        == instr.polarity);
         OP_BRANCH_UNSIGNED_GE: cond = (status_flags_register[FLG_C] == instr.polarity);
         default:               cond = 1'b0;
      endcase
   end

   // Word arithmetic on the high:low pair
   logic [15:0] word_in;
   logic [15:0] word_res;
   logic [7:0]  word_flags;
   assign word_in  = {pair_hi_data, dst_data};
   assign word_res = (op == OP_WORD_ADD_IMM) ? word_in + {8'h00, instr.imm}
                                             : word_in - {8'h00, instr.imm};
   always_comb
   begin
      word_flags = status_flags_register;
      word_flags[FLG_Z] = (word_res == 16'h0000);
      word_flags[FLG_N] = word_res[15];
      if (op == OP_WORD_ADD_IMM)
      begin
         word_flags[FLG_V] = ~word_in[15] & word_res[15];
         word_flags[FLG_C] = word_in[15] & ~word_res[15];
      end
      else
      begin
         word_flags[FLG_V] = word_in[15] & ~word_res[15];
         word_flags[FLG_C] = ~word_in[15] & word_res[15];
      end
      word_flags[FLG_S] = word_flags[FLG_N] ^ word_flags[FLG_V];
   end

   // *********************************************
   // Cycle count and next program counter
   // *********************************************
   logic [2:0]  cycles;
   logic [15:0] pc_target;
   logic [15:0] pc_seq;
   assign pc_seq = pc_r + PC_STEP;

   always_comb
   begin
      cycles    = CYC_ONE;
      pc_target = pc_seq;
      case (op)
         OP_WORD_ADD_IMM, OP_WORD_SUB_IMM: cycles = CYC_TWO;
         OP_POINTER_JUMP:
         begin
            cycles    = CYC_TWO;
            pc_target = pointer_data;
         end
         OP_POINTER_CALL:
         begin
            cycles    = CYC_THREE;
            pc_target = pointer_data;
         end
         OP_RETURN, OP_INT_RETURN:
         begin
            cycles    = CYC_FOUR;
            pc_target = stack_data;
         end
         OP_COMPARE_SKIP_EQ, OP_SKIP_REG_BIT, OP_SKIP_IO_BIT:
         begin
            if (cond)
            begin
               // Skipping a two-word instruction costs one more fetch
               cycles    = instr.next_two_word ? CYC_THREE : CYC_TWO;
               pc_target = instr.next_two_word ? pc_r + 16'h0003 : pc_r + 16'h0002;
            end
         end
         OP_BRANCH_FLAG, OP_BRANCH_SIGNED_GE, OP_BRANCH_UNSIGNED_GE:
         begin
            if (cond)
            begin
               cycles    = CYC_TWO;
               pc_target = pc_rel(pc_r, instr.offset);
            end
         end
         default: cycles = CYC_ONE;
      endcase
   end

   // *********************************************
   // Sequencer
   // *********************************************
   typedef enum logic [0:0] {ST_IDLE, ST_WAIT} cab_state_t;
   cab_state_t  state_r;
   logic [2:0]  cnt_r;
   logic [15:0] pc_hold_r;
   logic        start;
   assign start = (state_r == ST_IDLE) && instr_valid;

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         state_r     <= ST_IDLE;
         cnt_r       <= 3'h0;
         pc_hold_r   <= PC_RST;
         pc_r        <= PC_RST;
         busy_r      <= 1'b0;
         done_r      <= 1'b0;
         push_r      <= 1'b0;
         pop_r       <= 1'b0;
         push_data_r <= PC_RST;
         wr_lo_r     <= '0;
         wr_hi_r     <= '0;
         status_flags_register <= FLAGS_RST;
      end
      else
      begin
         done_r  <= 1'b0;
         push_r  <= 1'b0;
         pop_r   <= 1'b0;
         wr_lo_r <= '0;
         wr_hi_r <= '0;
         case (state_r)
            ST_IDLE:
            begin
               if (start)
               begin
                  if (is_alu)
                  begin
                     status_flags_register <= alu_flags;
                     wr_lo_r <= '{we: alu_writes, addr: instr.dst, data: alu_res};
                  end
                  if (is_word)
                  begin
                     status_flags_register <= word_flags;
                     wr_lo_r <= '{we: 1'b1, addr: instr.dst, data: word_res[7:0]};
                  end
                  if (op == OP_POINTER_CALL)
                  begin
                     push_r      <= 1'b1;
                     push_data_r <= pc_seq;
                  end
                  if (op == OP_RETURN || op == OP_INT_RETURN)
                  begin
                     pop_r <= 1'b1;
                  end
                  if (op == OP_INT_RETURN)
                  begin
                     status_flags_register[FLG_I] <= 1'b1;
                  end
                  if (cycles == CYC_ONE)
                  begin
                     pc_r   <= pc_target;
                     done_r <= 1'b1;
                  end
                  else
                  begin
                     state_r   <= ST_WAIT;
                     busy_r    <= 1'b1;
                     cnt_r     <= cycles - CYC_ONE;
                     pc_hold_r <= pc_target;
                  end
               end
            end
            ST_WAIT:
            begin
               if (is_word && cnt_r == CYC_ONE)
               begin
                  // High byte written in the second cycle
                  wr_hi_r <= '{we: 1'b1, addr: instr.dst + 5'h01, data: word_res[15:8]};
               end
               if (cnt_r == CYC_ONE)
               begin
                  state_r <= ST_IDLE;
                  busy_r  <= 1'b0;
                  done_r  <= 1'b1;
                  pc_r    <= pc_hold_r;
               end
               cnt_r <= cnt_r - CYC_ONE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // *********************************************
   // Checks
   // *********************************************
   sequence start_one_s;
      start && cycles == CYC_ONE;
   endsequence

   single_cycle_a: assert property (@(posedge mclk) disable iff (sys_rst)
      start_one_s |=> done_r && !busy_r)
      else $error("single-cycle op did not finish next edge");
   word_two_a: assert property (@(posedge mclk) disable iff (sys_rst)
      start && is_word |=> busy_r ##1 done_r && !busy_r)
      else $error("word op did not take two cycles");
   call_three_a: assert property (@(posedge mclk) disable iff (sys_rst)
      start && op == OP_POINTER_CALL |=> push_r && busy_r ##1 busy_r ##1 done_r && pc_r == $past(pointer_data, 3))
      else $error("pointer call timing wrong");
   return_four_a: assert property (@(posedge mclk) disable iff (sys_rst)
      start && op == OP_INT_RETURN |=> pop_r && status_flags_register[FLG_I] ##3 done_r)
      else $error("interrupt return wrong");
   compare_nowrite_a: assert property (@(posedge mclk) disable iff (sys_rst)
      start && (op == OP_COMPARE_IMM || op == OP_TEST) |=> !wr_lo_r.we)
      else $error("compare wrote a register");
   logic_carry_a: assert property (@(posedge mclk) disable iff (sys_rst)
      start && op == OP_AND_IMM |=> status_flags_register[FLG_C] == $past(status_flags_register[FLG_C])
      && !status_flags_register[FLG_V])
      else $error("logic op disturbed carry or overflow");
   branch_taken_a: assert property (@(posedge mclk) disable iff (sys_rst)
      start && is_branch && cond |=> busy_r ##1 pc_r == $past(pc_r, 2) + $past(instr.offset, 2) + PC_STEP)
      else $error("taken branch target wrong");
   branch_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
      start && (is_branch || is_skip) && !cond |=> done_r && pc_r == $past(pc_r) + PC_STEP)
      else $error("untaken branch did not fall through");
endmodule

// ---- core/cab_pkg.sv ----
// Package: constants and carriers for the execute block
package cab_pkg;
   // *********************************************
   // Status flag bit positions
   // *********************************************
   localparam int FLG_C = 0;
   localparam int FLG_Z = 1;
   localparam int FLG_N = 2;
   localparam int FLG_V = 3;
   localparam int FLG_S = 4;
   localparam int FLG_H = 5;
   localparam int FLG_T = 6;
   localparam int FLG_I = 7;
   localparam logic [7:0]  FLAGS_RST = 8'h00;
   localparam logic [15:0] PC_RST    = 16'h0000;
   // *********************************************
   // Cycle counts
   // *********************************************
   localparam logic [2:0] CYC_ONE   = 3'h1;
   localparam logic [2:0] CYC_TWO   = 3'h2;
   localparam logic [2:0] CYC_THREE = 3'h3;
   localparam logic [2:0] CYC_FOUR  = 3'h4;
   localparam logic [15:0] PC_STEP  = 16'h0001;

   typedef enum logic [4:0] {
      OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_BYTE_SUB_IMM, OP_SUB_CARRY_IMM,
      OP_AND_IMM, OP_OR_IMM, OP_SET_MASK, OP_CLEAR_MASK, OP_TEST,
      OP_WORD_ADD_IMM, OP_WORD_SUB_IMM, OP_COMPARE_IMM,
      OP_POINTER_JUMP, OP_POINTER_CALL, OP_COMPARE_SKIP_EQ,
      OP_SKIP_REG_BIT, OP_SKIP_IO_BIT, OP_BRANCH_FLAG,
      OP_BRANCH_SIGNED_GE, OP_BRANCH_UNSIGNED_GE, OP_RETURN, OP_INT_RETURN,
      OP_NOP
   } cab_op_t;

   // One decoded instruction from the fetch side
   typedef struct packed {
      cab_op_t     op;
      logic [4:0]  dst;
      logic [4:0]  src;
      logic [7:0]  imm;
      logic [2:0]  bitsel;
      logic        polarity;
      logic [15:0] offset;
      logic        next_two_word;
   } cab_instr_t;

   // Register file write request
   typedef struct packed {
      logic       we;
      logic [4:0] addr;
      logic [7:0] data;
   } cab_wr_t;
endpackage

// ---- verification/cab_regfile_model.sv ----
// Register file, I/O register and stack model facing the execute block
`timescale 1ns/100ps
module cab_regfile_model
   import cab_pkg::*;
(
   input  wire logic        mclk,
   input  wire cab_instr_t  instr,
   input  wire cab_wr_t     wr_lo_r,
   input  wire cab_wr_t     wr_hi_r,
   input  wire logic        push_r,
   input  wire logic [15:0] push_data_r,
   input  wire logic        pop_r,
   output logic [7:0]       dst_data,
   output logic [7:0]       src_data,
   output logic [7:0]       pair_hi_data,
   output logic [15:0]      pointer_data,
   output logic [7:0]       io_data,
   output logic [15:0]      stack_data
);
   logic [7:0]  rf [32];
   logic [7:0]  io_r;
   logic [15:0] top_r;
   logic [15:0] pops;
   initial
   begin
      foreach (rf[j]) rf[j] = 8'h00;
      io_r  = 8'h00;
      top_r = 16'h0000;
      pops  = 16'h0000;
   end
   assign dst_data     = rf[instr.dst];
   assign src_data     = rf[instr.src];
   assign pair_hi_data = rf[instr.dst + 5'h01];
   assign pointer_data = {rf[31], rf[30]};
   assign io_data      = io_r;
   // Pop keeps the top visible so the return target holds until done
   assign stack_data   = top_r;
   always @(posedge mclk)
   begin
      if (wr_lo_r.we) rf[wr_lo_r.addr] <= wr_lo_r.data;
      if (wr_hi_r.we) rf[wr_hi_r.addr] <= wr_hi_r.data;
      if (push_r) top_r <= push_data_r;
      if (pop_r) pops <= pops + 16'h0001;
   end
endmodule

// ---- verification/cpu_alu_branch_execute_test.sv ----
// Self-checking bench for the execute block
`timescale 1ns/100ps
module cpu_alu_branch_execute_test import cab_pkg::*;;
   typedef struct packed {
      cab_op_t     op;
      logic [4:0]  s;
      logic [2:0]  b;
      logic        p;
      logic        t;
      logic [15:0] dl;
      logic [2:0]  cy;
   } cab_row_t;
   typedef struct packed {
      cab_op_t    op;
      logic [7:0] a;
      logic [7:0] k;
      logic [7:0] r;
      logic [7:0] f;
   } cab_lg_t;
   typedef struct packed {
      cab_op_t    op;
      logic [2:0] b;
      logic       p;
      logic       tk;
   } cab_br_t;
   logic        mclk;
   logic        sys_rst;
   logic        instr_valid;
   cab_instr_t  instr;
   logic [7:0]  dst_data;
   logic [7:0]  src_data;
   logic [7:0]  pair_hi_data;
   logic [7:0]  io_data;
   logic [15:0] pointer_data;
   logic [15:0] stack_data;
   logic        busy_r;
   logic        done_r;
   logic        push_r;
   logic        pop_r;
   logic [15:0] pc_r;
   logic [15:0] push_data_r;
   logic [7:0]  status_flags_register;
   cab_wr_t     wr_lo_r;
   cab_wr_t     wr_hi_r;
   int          err_count = 0;
   int          n_checks = 0;
   int          ticks = 0;
   logic [15:0] pc_x;

   cab_execute u_cab_execute (.mclk, .sys_rst, .instr_valid, .instr, .dst_data, .src_data,
      .pair_hi_data, .pointer_data, .io_data, .stack_data, .busy_r, .done_r, .pc_r,
      .status_flags_register, .wr_lo_r, .wr_hi_r, .push_r, .push_data_r, .pop_r);
   cab_regfile_model u_cab_regfile_model (.mclk, .instr, .wr_lo_r, .wr_hi_r, .push_r,
      .push_data_r, .pop_r, .dst_data, .src_data, .pair_hi_data, .pointer_data, .io_data,
      .stack_data);

   always #4 mclk = ~mclk;

   // *********************************************
   // Shared helpers
   // *********************************************
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic summarize;
      $display("Checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   function automatic cab_instr_t mk(cab_op_t o, logic [4:0] d, logic [4:0] s, logic [7:0] k,
                                     logic [2:0] b, logic p, logic t);
      return '{o, d, s, k, b, p, 16'h0010, t};
   endfunction

   function automatic cab_instr_t mka(cab_op_t o, logic [4:0] d, logic [4:0] s, logic [7:0] k);
      return mk(o, d, s, k, 3'h0, 1'b0, 1'b0);
   endfunction

   task automatic setr(input int i, input logic [7:0] v);
      u_cab_regfile_model.rf[i] = v;
   endtask

   task automatic chkr(input string nm, input int i, input logic [7:0] v);
      chk(nm, {8'h00, v}, {8'h00, u_cab_regfile_model.rf[i]});
   endtask

   // One instruction; extra idle cycle lets the model take the writes
   task automatic go(input cab_instr_t i, input logic [2:0] cy, input logic [15:0] pc_e,
                     input logic [7:0] fm, input logic [7:0] fe);
      int n;
      int nb;
      @(negedge mclk);
      instr = i;
      instr_valid = 1'b1;
      n = 0;
      nb = 0;
      do
      begin
         @(negedge mclk);
         instr_valid = 1'b0;
         n++;
         if (busy_r === 1'b1)
            nb++;
      end while (done_r !== 1'b1 && n < 6);
      chk("cycles", {13'h0000, cy}, n[15:0]);
      chk("busy", {13'h0000, cy - 3'h1}, nb[15:0]);
      chk("pc", pc_e, pc_r);
      chk("flags", {8'h00, fe & fm}, {8'h00, status_flags_register & fm});
      @(negedge mclk);
      pc_x = pc_e;
   endtask

   // *********************************************
   // Scenarios
   // *********************************************
   task automatic s_add;
      setr(1, 8'hFF);
      setr(2, 8'h01);
      setr(3, 8'h7F);
      go(mka(OP_ADD, 5'h01, 5'h02, 8'h00), CYC_ONE, pc_x + PC_STEP, 8'h2F, 8'h23);
      chkr("add", 1, 8'h00);
      go(mka(OP_ADC, 5'h03, 5'h04, 8'h00), CYC_ONE, pc_x + PC_STEP, 8'h2F, 8'h2C);
      chkr("adc", 3, 8'h80);
   endtask

   task automatic s_word;
      setr(24, 8'hFF);
      setr(25, 8'h7F);
      go(mka(OP_WORD_ADD_IMM, 5'h18, 5'h00, 8'h01), CYC_TWO, pc_x + PC_STEP, 8'h1F, 8'h0C);
      chkr("wadd lo", 24, 8'h00);
      chkr("wadd hi", 25, 8'h80);
      go(mka(OP_WORD_SUB_IMM, 5'h1A, 5'h00, 8'h01), CYC_TWO, pc_x + PC_STEP, 8'h1F, 8'h15);
      chkr("wsub lo", 26, 8'hFF);
      chkr("wsub hi", 27, 8'hFF);
   endtask

   task automatic s_sub;
      setr(16, 8'h10);
      setr(18, 8'h05);
      setr(19, 8'h04);
      setr(20, 8'h80);
      go(mka(OP_BYTE_SUB_IMM, 5'h10, 5'h00, 8'h01), CYC_ONE, pc_x + PC_STEP, 8'h2F, 8'h20);
      chkr("byte_sub_immediate", 16, 8'h0F);
      go(mka(OP_SUB, 5'h10, 5'h13, 8'h00), CYC_ONE, pc_x + PC_STEP, 8'h2F, 8'h00);
      chkr("sub", 16, 8'h0B);
      go(mka(OP_BYTE_SUB_IMM, 5'h11, 5'h00, 8'h01), CYC_ONE, pc_x + PC_STEP, 8'h2F, 8'h25);
      go(mka(OP_SBC, 5'h12, 5'h13, 8'h00), CYC_ONE, pc_x + PC_STEP, 8'h2F, 8'h00);
      chkr("sbc", 18, 8'h00);
      go(mka(OP_BYTE_SUB_IMM, 5'h15, 5'h00, 8'h01), CYC_ONE, pc_x + PC_STEP, 8'h2F, 8'h25);
      go(mka(OP_SUB_CARRY_IMM, 5'h14, 5'h00, 8'h01), CYC_ONE, pc_x + PC_STEP, 8'h2F, 8'h28);
      chkr("sub_carry_immediate", 20, 8'h7E);
   endtask

   task automatic s_logic;
      cab_lg_t t[5];
      t = '{'{OP_AND_IMM, 8'hF0, 8'h80, 8'h80, 8'h25}, '{OP_OR_IMM, 8'h00, 8'h00, 8'h00, 8'h23},
            '{OP_SET_MASK, 8'h01, 8'h80, 8'h81, 8'h25}, '{OP_CLEAR_MASK, 8'h81, 8'h01, 8'h80, 8'h25},
            '{OP_TEST, 8'h00, 8'h00, 8'h00, 8'h23}};
      setr(21, 8'h00);
      go(mka(OP_BYTE_SUB_IMM, 5'h15, 5'h00, 8'h01), CYC_ONE, pc_x + PC_STEP, 8'h2F, 8'h25);
      foreach (t[j])
      begin
         setr(22, t[j].a);
         go(mka(t[j].op, 5'h16, 5'h16, t[j].k), CYC_ONE, pc_x + PC_STEP, 8'h2F, t[j].f);
         chkr("logic", 22, t[j].r);
      end
   endtask

   task automatic s_jump;
      setr(30, 8'h34);
      setr(31, 8'h12);
      go(mka(OP_POINTER_JUMP, 5'h00, 5'h00, 8'h00), CYC_TWO, 16'h1234, 8'hEF, 8'h23);
      setr(30, 8'h00);
      setr(31, 8'h02);
      go(mka(OP_POINTER_CALL, 5'h00, 5'h00, 8'h00), CYC_THREE, 16'h0200, 8'hEF, 8'h23);
      chk("push", 16'h1235, u_cab_regfile_model.top_r);
      go(mka(OP_RETURN, 5'h00, 5'h00, 8'h00), CYC_FOUR, 16'h1235, 8'hEF, 8'h23);
      go(mka(OP_INT_RETURN, 5'h00, 5'h00, 8'h00), CYC_FOUR, 16'h1235, 8'hEF, 8'hA3);
      chk("pops", 16'h0002, u_cab_regfile_model.pops);
   endtask

   task automatic s_skip;
      cab_row_t t[7];
      t = '{'{OP_COMPARE_SKIP_EQ, 5'h02, 3'h0, 1'b0, 1'b1, 16'h0003, 3'h3},
            '{OP_COMPARE_SKIP_EQ, 5'h03, 3'h0, 1'b0, 1'b0, 16'h0001, 3'h1},
            '{OP_SKIP_REG_BIT, 5'h03, 3'h3, 1'b0, 1'b0, 16'h0002, 3'h2},
            '{OP_SKIP_REG_BIT, 5'h03, 3'h3, 1'b1, 1'b0, 16'h0001, 3'h1},
            '{OP_SKIP_REG_BIT, 5'h03, 3'h0, 1'b1, 1'b0, 16'h0002, 3'h2},
            '{OP_SKIP_IO_BIT, 5'h00, 3'h7, 1'b1, 1'b1, 16'h0003, 3'h3},
            '{OP_SKIP_IO_BIT, 5'h00, 3'h7, 1'b0, 1'b0, 16'h0001, 3'h1}};
      setr(1, 8'h55);
      setr(2, 8'h55);
      setr(3, 8'hF7);
      u_cab_regfile_model.io_r = 8'h80;
      foreach (t[j])
         go(mk(t[j].op, 5'h01, t[j].s, 8'h00, t[j].b, t[j].p, t[j].t), t[j].cy, pc_x + t[j].dl,
            8'hEF, 8'hA3);
   endtask

   task automatic s_branch;
      cab_br_t t[14];
      t = '{'{OP_BRANCH_FLAG, 3'h0, 1'b1, 1'b1}, '{OP_BRANCH_FLAG, 3'h1, 1'b1, 1'b0},
            '{OP_BRANCH_FLAG, 3'h1, 1'b0, 1'b1}, '{OP_BRANCH_FLAG, 3'h6, 1'b0, 1'b1},
            '{OP_BRANCH_FLAG, 3'h6, 1'b1, 1'b0}, '{OP_BRANCH_FLAG, 3'h5, 1'b1, 1'b1},
            '{OP_BRANCH_FLAG, 3'h3, 1'b1, 1'b0}, '{OP_BRANCH_FLAG, 3'h3, 1'b0, 1'b1},
            '{OP_BRANCH_FLAG, 3'h7, 1'b1, 1'b1}, '{OP_BRANCH_FLAG, 3'h7, 1'b0, 1'b0},
            '{OP_BRANCH_SIGNED_GE, 3'h0, 1'b0, 1'b0}, '{OP_BRANCH_SIGNED_GE, 3'h0, 1'b1, 1'b1},
            '{OP_BRANCH_UNSIGNED_GE, 3'h0, 1'b0, 1'b0}, '{OP_BRANCH_UNSIGNED_GE, 3'h0, 1'b1, 1'b1}};
      setr(22, 8'h00);
      go(mka(OP_COMPARE_IMM, 5'h16, 5'h16, 8'h01), CYC_ONE, pc_x + PC_STEP, 8'h2F, 8'h25);
      chkr("cpi", 22, 8'h00);
      foreach (t[j])
         go(mk(t[j].op, 5'h00, 5'h00, 8'h00, t[j].b, t[j].p, 1'b0), t[j].tk ? CYC_TWO : CYC_ONE,
            pc_x + (t[j].tk ? 16'h0011 : PC_STEP), 8'hEF, 8'hA5);
   endtask

   // Ceiling well above the under two hundred cycles the run needs
   always @(posedge mclk)
   begin
      ticks++;
      if (ticks == 2000)
      begin
         err_count++;
         summarize;
      end
   end

   initial
   begin
      mclk = 1'b0;
      sys_rst = 1'b1;
      instr_valid = 1'b0;
      instr = '0;
      pc_x = PC_RST;
      repeat (12) @(negedge mclk);
      sys_rst = 1'b0;
      chk("reset pc", PC_RST, pc_r);
      chk("reset flags", {8'h00, FLAGS_RST}, {8'h00, status_flags_register});
      s_add;
      s_word;
      s_sub;
      s_logic;
      s_jump;
      s_skip;
      s_branch;
      summarize;
   end
endmodule
